// ---- rtl/dram_cmd_cfg.svh ----
// timing counts, field positions and codes for the dram command front end
`ifndef DRAM_CMD_CFG_SVH
`define DRAM_CMD_CFG_SVH
`define BANK_W        3
`define ADDR_W        14
`define COL_W         10
`define NUM_BANKS     8
`define AP_BIT        10
`define BC_BIT        12
`define CLK_PERIOD_NS 10
`define T_PRE_NS      20
`define T_PRE_CYC     ((`T_PRE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BURST_FULL    4
`define BURST_CHOP    2
`endif

// ---- rtl/dram_cmd_pkg.sv ----
// types for the dram command front end
package dram_cmd_pkg;
  typedef enum logic [2:0] {
    cmd_nop, cmd_open_row, cmd_precharge, cmd_read, cmd_write, cmd_mode_set
  } cmd_kind_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [2:0]  bank_select;
    logic [13:0] address_in;
  } pin_bus_t;

  typedef struct packed {
    logic        valid;
    cmd_kind_t   kind;
    logic [2:0]  bank;
    logic [13:0] row;
    logic [9:0]  col;
    logic        auto_pre;
    logic        all_banks;
    logic        chop;
    logic [13:0] opcode;
  } cmd_t;
endpackage

// ---- rtl/dram_command_pin_decode.sv ----
// command and address pin decoder with bank state tracking
//
// Contract
// - sample all command, bank and address pins on the clock crossing edge
// - read data beats aligned to both edges of the clock
// - clock enable low freezes internal clock, outputs and burst address from next cycle
// - clock enable low with all banks idle enters power-down or self-refresh
// - three-bit bank select chooses the bank each command applies to
// - fourteen-bit row on open row, ten-bit column on read or write
// - mode set takes its operation code from the address pins
// - address bit 10 on read or write requests auto precharge
// - address bit 10 on precharge selects all banks, else one bank
// - address bit 12 on read or write: high full burst, low chopped
// - decoder acts only while chip select sampled low
// - cs, ras low, cas high: open row if we high, precharge if low
// - open row makes bank active; precharge returns bank(s) idle after completion
// - cs low, ras high, cas low: read if we high, write if low
`timescale 1ns/1ps
`include "dram_cmd_cfg.svh"
module dram_command_pin_decode #(
  parameter int PRE_CYC = `T_PRE_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire dram_cmd_pkg::pin_bus_t pins,
  output dram_cmd_pkg::cmd_t         cmd_out,
  output logic [`NUM_BANKS-1:0]      bank_active_r,
  output logic                       low_power_r,
  output logic                       clock_frozen_r,
  output logic [`COL_W-1:0]          burst_addr_r,
  output logic [1:0]                 read_beat_r
);
  import dram_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin capture: clock is the internal image of the crossing edge
  pin_bus_t  s1_r;
  pin_bus_t  s2_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // idle pins read as clock enabled, so leaving reset is not taken as a suspension
      s1_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
      s2_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end

  // suspension begins the cycle after clock enable is seen low
  logic run;
  assign run = ~clock_frozen_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) clock_frozen_r <= 1'b0;
    else clock_frozen_r <= ~s2_r.cke;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  cmd_kind_t kind;
  always_comb begin
    kind = cmd_nop;
    if (!s2_r.cs_n) begin
      unique case ({s2_r.ras_n, s2_r.cas_n, s2_r.we_n})
        3'b011: kind = cmd_open_row;
        3'b010: kind = cmd_precharge;
        3'b101: kind = cmd_read;
        3'b100: kind = cmd_write;
        3'b000: kind = cmd_mode_set;
        default: kind = cmd_nop;
      endcase
    end
  end

  logic is_col;
  logic is_pre;
  logic is_open;
  assign is_col  = run && (kind == cmd_read || kind == cmd_write);
  assign is_pre  = run && kind == cmd_precharge;
  assign is_open = run && kind == cmd_open_row;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_out <= '0;
    end else if (run) begin
      cmd_out.valid     <= kind != cmd_nop;
      cmd_out.kind      <= kind;
      cmd_out.bank      <= s2_r.bank_select;
      cmd_out.row       <= (kind == cmd_open_row) ? s2_r.address_in : '0;
      cmd_out.col       <= is_col ? s2_r.address_in[`COL_W-1:0] : '0;
      cmd_out.auto_pre  <= is_col & s2_r.address_in[`AP_BIT];
      cmd_out.all_banks <= is_pre & s2_r.address_in[`AP_BIT];
      cmd_out.chop      <= is_col & ~s2_r.address_in[`BC_BIT];
      cmd_out.opcode    <= (kind == cmd_mode_set) ? s2_r.address_in : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bank state: precharge (direct or auto) closes after PRE_CYC cycles
  localparam int CW = $clog2(PRE_CYC + 1);
  localparam int BL = `BURST_FULL;
  logic [`NUM_BANKS-1:0] pre_mask;
  logic [`NUM_BANKS-1:0] pend_r;
  logic [CW-1:0]         pre_cnt_r;
  logic [1:0]            beats_r;
  logic                  ap_pend_r;
  logic [`BANK_W-1:0]    ap_bank_r;

  always_comb begin
    pre_mask = '0;
    if (is_pre) begin
      if (s2_r.address_in[`AP_BIT]) pre_mask = '1;
      else pre_mask[s2_r.bank_select] = 1'b1;
    end
    if (ap_pend_r && run && beats_r == 2'd0) pre_mask[ap_bank_r] = 1'b1;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r    <= '0;
      pre_cnt_r <= '0;
    end else if (run) begin
      if (|pre_mask) begin
        pend_r    <= pend_r | pre_mask;
        pre_cnt_r <= CW'(PRE_CYC);
      end else if (pre_cnt_r > CW'(1)) begin
        pre_cnt_r <= pre_cnt_r - CW'(1);
      end else begin
        pend_r    <= '0;
        pre_cnt_r <= '0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bank_active_r <= '0;
    end else if (run) begin
      if (pre_cnt_r == CW'(1) && !(|pre_mask)) bank_active_r <= bank_active_r & ~pend_r;
      if (is_open) bank_active_r[s2_r.bank_select] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // burst address and read beats; both stand still while suspended
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      burst_addr_r <= '0;
      beats_r      <= '0;
      read_beat_r  <= '0;
      ap_pend_r    <= 1'b0;
      ap_bank_r    <= '0;
    end else if (run) begin
      if (is_col) begin
        burst_addr_r <= s2_r.address_in[`COL_W-1:0];
        beats_r      <= s2_r.address_in[`BC_BIT] ? 2'(BL - 1) : 2'(`BURST_CHOP - 1);
        read_beat_r  <= {kind == cmd_read, kind == cmd_read};
        ap_pend_r    <= s2_r.address_in[`AP_BIT];
        ap_bank_r    <= s2_r.bank_select;
      end else if (beats_r != 2'd0) begin
        burst_addr_r <= burst_addr_r + `COL_W'(2);
        beats_r      <= beats_r - 2'd1;
      end else begin
        read_beat_r  <= '0;
        ap_pend_r    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // low power entry: clock enable low with every bank idle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) low_power_r <= 1'b0;
    else low_power_r <= ~s2_r.cke & ~(|bank_active_r);
  end

  ////////////////////////////////////////////////////////////////////////////////
  cs_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
    s2_r.cs_n && run |=> !cmd_out.valid) else $error("command taken with chip select high");
  freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
    clock_frozen_r |=> $stable(burst_addr_r) && $stable(cmd_out)) else $error("frozen state moved");
  open_bank_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_open |=> bank_active_r[$past(s2_r.bank_select)]) else $error("bank not opened");
  all_pre_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_pre && s2_r.address_in[`AP_BIT] |=> cmd_out.all_banks) else $error("all-bank flag lost");
  chop_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_col |=> cmd_out.chop == !$past(s2_r.address_in[`BC_BIT])) else $error("chop wrong");
  nop_a: assert property (@(posedge clock) disable iff (sys_rst)
    run && kind == cmd_nop && !(|pre_mask) && pre_cnt_r == '0 |=> $stable(bank_active_r))
    else $error("nop changed banks");
  lowpow_a: assert property (@(posedge clock) disable iff (sys_rst)
    !s2_r.cke && bank_active_r == '0 |=> low_power_r) else $error("no low power entry");
  opcode_a: assert property (@(posedge clock) disable iff (sys_rst)
    run && kind == cmd_mode_set |=> cmd_out.opcode == $past(s2_r.address_in))
    else $error("opcode not taken");
  // read in two steps: the command is taken, then both beat enables rise
  sequence read_taken_s;
    run && kind == cmd_read;
  endsequence
  sequence beats_on_s;
    read_beat_r == 2'b11;
  endsequence
  read_beat_a: assert property (@(posedge clock) disable iff (sys_rst)
    read_taken_s |=> beats_on_s) else $error("read beats not enabled");
  // column access in two steps: the command is taken, then the burst start is loaded
  sequence col_taken_s;
    is_col;
  endsequence
  sequence burst_loaded_s;
    burst_addr_r == $past(s2_r.address_in[`COL_W-1:0]);
  endsequence
  burst_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    col_taken_s |=> burst_loaded_s) else $error("burst address not loaded");
  decode_row_a: assert property (@(posedge clock) disable iff (sys_rst)
    run && !s2_r.cs_n && !s2_r.ras_n && s2_r.cas_n |=> cmd_out.valid &&
    cmd_out.kind == ($past(s2_r.we_n) ? cmd_open_row : cmd_precharge))
    else $error("row command misdecoded");
  decode_col_a: assert property (@(posedge clock) disable iff (sys_rst)
    run && !s2_r.cs_n && s2_r.ras_n && !s2_r.cas_n |=> cmd_out.valid &&
    cmd_out.kind == ($past(s2_r.we_n) ? cmd_read : cmd_write))
    else $error("column command misdecoded");
  ap_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_col |=> cmd_out.auto_pre == $past(s2_r.address_in[`AP_BIT]))
    else $error("auto precharge flag wrong");
  one_bank_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_pre && !s2_r.address_in[`AP_BIT] |=> !cmd_out.all_banks &&
    cmd_out.bank == $past(s2_r.bank_select)) else $error("single bank precharge wrong");
  row_take_a: assert property (@(posedge clock) disable iff (sys_rst)
    is_open |=> cmd_out.row == $past(s2_r.address_in)) else $error("row address lost");
  freeze_go_a: assert property (@(posedge clock) disable iff (sys_rst)
    !s2_r.cke |=> clock_frozen_r) else $error("clock not suspended");
  wake_a: assert property (@(posedge clock) disable iff (sys_rst)
    s2_r.cke |=> !low_power_r) else $error("low power held with clock enabled");
endmodule

// ---- sim/dram_ctrl_model.sv ----
// controller model that drives the command pins
`timescale 1ns/1ps
module dram_ctrl_model (
  input  wire logic          clock,
  output dram_cmd_pkg::pin_bus_t pins
);
  import dram_cmd_pkg::*;
  initial pins = {5'h1f, 3'h0, 14'h0};
  // idle lines toggle so a stale value never looks like a held one
  task automatic send(input logic [3:0] st, input logic [2:0] bk,
                      input logic [13:0] ad, input logic ck);
    @(posedge clock);
    #1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = st;
    pins.bank_select = bk;
    pins.address_in  = ad;
    pins.cke         = ck;
    @(posedge clock);
    #1;
    pins.cs_n        = 1'b1;
    pins.bank_select = ~bk;
    pins.address_in  = ~ad;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the command pin decoder
`timescale 1ns/1ps
`include "dram_cmd_cfg.svh"
module tb_top;
  import dram_cmd_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  pin_bus_t    pins;
  cmd_t        cmd_out;
  logic [7:0]  bank_active_r, eb;
  logic        low_power_r, clock_frozen_r, frz;
  logic [9:0]  burst_addr_r, ea;
  logic [1:0]  read_beat_r;
  int          fail_count = 0, cmp_count = 0, seed = 62, i, n;
  int          act[8];
  cmd_kind_t   k;
  logic [3:0]  s;
  always #5 clock = ~clock;
  dram_ctrl_model dram_ctrl_model_i (.clock(clock), .pins(pins));
  dram_command_pin_decode #(.PRE_CYC(1)) dram_command_pin_decode_i (.clock(clock),
    .sys_rst(sys_rst), .pins(pins), .cmd_out(cmd_out), .bank_active_r(bank_active_r),
    .low_power_r(low_power_r), .clock_frozen_r(clock_frozen_r),
    .burst_addr_r(burst_addr_r), .read_beat_r(read_beat_r));
  //////////////////////////////////////////////////////////////////////////////
  // one compare task per kind of result: command fields, bank states, power states
  task automatic chk_cmd(input string w, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_bank(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error banks expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_pwr(input string w, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reference decode; the bank model is plain integers
  task automatic run(input logic [3:0] st, input logic [2:0] bk, input logic [13:0] ad,
                     input logic ck);
    k = st[3] ? cmd_nop : st == 4'h3 ? cmd_open_row : st == 4'h2 ? cmd_precharge :
        st == 4'h5 ? cmd_read : st == 4'h4 ? cmd_write : st == 4'h0 ? cmd_mode_set : cmd_nop;
    dram_ctrl_model_i.send(st, bk, ad, ck);
    n = 0;
    while (cmd_out.valid !== 1'b1 && n < 8) begin
      @(posedge clock);
      #2;
      n++;
    end
    if (k == cmd_nop || frz) chk_cmd("valid", 14'h0, n < 8);
    else begin
      chk_cmd("valid", 14'h1, n < 8);
      if (n == 8) test_done;
      chk_cmd("kind", k, cmd_out.kind);
      if (k == cmd_open_row) begin
        chk_cmd("row", ad, cmd_out.row);
        act[bk] = 1;
      end
      if (k == cmd_read || k == cmd_write) begin
        chk_cmd("col", ad[9:0], cmd_out.col);
        chk_cmd("burst", ad[9:0], burst_addr_r);
        chk_cmd("autopre", ad[10], cmd_out.auto_pre);
        chk_cmd("chop", !ad[12], cmd_out.chop);
        if (k == cmd_read) chk_cmd("beats", 14'h3, read_beat_r);
        else chk_cmd("beats", 14'h0, read_beat_r);
        if (ad[10]) act[bk] = 0;
      end
      if (k != cmd_mode_set && !(k == cmd_precharge && ad[10]))
        chk_cmd("bank", bk, cmd_out.bank);
      if (k == cmd_precharge) begin
        chk_cmd("allbanks", ad[10], cmd_out.all_banks);
        for (i = 0; i < 8; i++) if (ad[10] || i == bk) act[i] = 0;
      end
      if (k == cmd_mode_set) chk_cmd("opcode", ad, cmd_out.opcode);
    end
    repeat (16) @(posedge clock);
    #2;
    if (!frz && (k == cmd_read || k == cmd_write)) begin
      ea = 10'(ad[9:0] + 2 * (ad[12] ? `BURST_FULL - 1 : `BURST_CHOP - 1));
      chk_cmd("burst_end", ea, burst_addr_r);
    end
    for (i = 0; i < 8; i++) eb[i] = act[i][0];
    chk_bank(eb, bank_active_r);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    frz = 1'b0;
    for (i = 0; i < 8; i++) act[i] = 0;
    repeat (6) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    for (int j = 0; j < 16; j++) run(j[3:0], j[2:0], 14'h1555 ^ 14'(j * 1321), 1'b1);
    for (int j = 0; j < 40; j++) begin
      s = $random(seed);
      s[3] = s[3] & s[2];
      run(s, 3'($random(seed)), 14'($random(seed)), 1'b1);
    end
    // clock enable drops mid burst: address and beat enables stand until it returns
    dram_ctrl_model_i.send(4'h5, 3'h4, 14'h1010, 1'b1);
    dram_ctrl_model_i.send(4'hf, 3'h0, 14'h0, 1'b0);
    repeat (8) @(posedge clock);
    #2;
    chk_cmd("burst_held", 14'h014, burst_addr_r);
    chk_cmd("beats_held", 14'h3, read_beat_r);
    chk_pwr("frozen", 1'b1, clock_frozen_r);
    run(4'hf, 3'h0, 14'h0, 1'b1);
    chk_cmd("burst_done", 14'h016, burst_addr_r);
    chk_cmd("beats_done", 14'h0, read_beat_r);
    run(4'h2, 3'h0, 14'h0400, 1'b1);
    run(4'hf, 3'h0, 14'h0, 1'b0);
    chk_pwr("lowpower", 1'b1, low_power_r);
    chk_pwr("frozen", 1'b1, clock_frozen_r);
    frz = 1'b1;
    run(4'h3, 3'h2, 14'h2a5a, 1'b0);
    frz = 1'b0;
    run(4'hf, 3'h0, 14'h0, 1'b1);
    chk_pwr("frozen", 1'b0, clock_frozen_r);
    run(4'h3, 3'h1, 14'h0f0f, 1'b1);
    run(4'hf, 3'h0, 14'h0, 1'b0);
    chk_pwr("lowpower", 1'b0, low_power_r);
    chk_pwr("frozen", 1'b1, clock_frozen_r);
    test_done;
  end
endmodule
